// *** src/isoc_pkg.sv ***
// Purpose: Shared constants for the input select and boost control block
// Assumes: 100 MHz mclk, analog comparators deliver clean synchronous levels
// Notes:   Current limit codes are plain 5-bit selections
package isoc_pkg;
    localparam int            CLK_MHZ            = 100;
    localparam int            BOOST_SHORT_MS     = 8;
    localparam int            BOOST_SHORT_CYC    = BOOST_SHORT_MS * 1000 * CLK_MHZ;
    localparam logic [4:0]    ILIM_DEFAULT_100MA = 5'h01;
    localparam logic [4:0]    CHG_FULL           = 5'h1F;
    localparam int            IRQ_BOOST_BIT      = 0;
    localparam int            IRQ_IDENT_BIT      = 1;
    localparam int            IRQ_INPUT_BIT      = 2;
    localparam int            IRQ_W              = 3;

    typedef enum logic [1:0] {
        ISOC_SRC_NONE,
        ISOC_SRC_USB,
        ISOC_SRC_ADAPTER,
        ISOC_SRC_BOOST
    } isoc_src_e;
endpackage

// *** src/isoc_input_qual.sv ***
// Purpose: Qualifies one power input from its three comparator levels
// Assumes: Comparator outputs are synchronous to mclk
// Notes:   Valid is registered so the flag comes straight from a flip-flop
`timescale 1ns/1ps
module isoc_input_qual (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic above_min,
    input  wire logic above_batt,
    input  wire logic below_over,
    output logic      valid_r
);
    logic valid_nxt;

    always_comb begin
        valid_nxt = above_min & above_batt & below_over; // RULE_15
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= valid_nxt;
        end
    end
endmodule

// *** src/isoc_top.sv ***
// Purpose: Input selection, current limit, undervoltage limit and boost control
// Assumes: Host writes come as strobes with data; all inputs synchronous
// Notes:   Boost short counter is a parameter so simulation can shorten it
`timescale 1ns/1ps
// What this block does
// RULE_01 - Separate 5-bit limits per input; apply the one for the active input
// RULE_02 - USB limit returns to 100mA default when USB power is removed
// RULE_03 - Adapter limit returns to default only when both inputs lose power
// RULE_04 - At input limit, cut charge current only enough to feed the load
// RULE_05 - Undervoltage current limiting near 4.3V, host bit disables it
// RULE_06 - Boost starts on grounded cable ident or on host enable request
// RULE_07 - Boost refused while any input powered or battery is low
// RULE_08 - Report boost running, battery low and boost fault flags
// RULE_09 - Boost feeds USB input only; preference bit ignored during boost
// RULE_10 - Output short shuts boost down after about 8ms and sets fault
// RULE_11 - Cable ident monitored always; status true when line is grounded
// RULE_12 - Change of cable ident status can raise interrupt when enabled
// RULE_13 - Lockout stops automatic boost start but keeps ident monitoring
// RULE_14 - Host request starts boost regardless of ident and lockout
// RULE_15 - Input valid needs above minimum, above battery margin, below over
// RULE_16 - Per-input valid flags; input changes interrupt when enabled
// RULE_17 - Both valid: adapter by default, USB when preference bit set
// RULE_18 - Event interrupts grouped in categories, each masked separately
// RULE_19 - Selected input fails while other valid: switch to the other
// RULE_20 - Host reads status after each interrupt before changing settings
module isoc_top #(
    parameter int BOOST_SHORT_CYCLES = isoc_pkg::BOOST_SHORT_CYC
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic                     usb_above_min,
    input  wire logic                     usb_above_batt,
    input  wire logic                     usb_below_over,
    input  wire logic                     adapter_above_min,
    input  wire logic                     adapter_above_batt,
    input  wire logic                     adapter_below_over,
    input  wire logic                     usb_power_present,
    input  wire logic                     adapter_power_present,
    input  wire logic                     battery_below_low,
    input  wire logic                     input_below_uv,
    input  wire logic                     input_limit_reached,
    input  wire logic                     boost_output_short,
    input  wire logic                     cable_ident_grounded,
    input  wire logic                     usb_limit_wr,
    input  wire logic [4:0]               usb_limit_wdata,
    input  wire logic                     adapter_limit_wr,
    input  wire logic [4:0]               adapter_limit_wdata,
    input  wire logic                     undervoltage_limit_off,
    input  wire logic                     usb_preference,
    input  wire logic                     auto_boost_lockout,
    input  wire logic                     boost_enable_request,
    input  wire logic                     boost_stop_request,
    input  wire logic                     fault_clear,
    input  wire logic [isoc_pkg::IRQ_W-1:0] irq_enable,
    input  wire logic                     irq_clear,
    output logic [4:0]                    usb_in_current_limit_sel,
    output logic [4:0]                    adapter_in_current_limit_sel,
    output logic [4:0]                    active_current_limit,
    output logic                          charge_throttle,
    output logic                          uv_limit_active,
    output logic                          usb_in_valid_flag,
    output logic                          adapter_in_valid_flag,
    output logic                          route_usb,
    output logic                          route_adapter,
    output logic                          boost_running_flag,
    output logic                          battery_low_flag,
    output logic                          boost_fault_flag,
    output logic                          cable_ident_status,
    output logic [isoc_pkg::IRQ_W-1:0]    irq_status,
    output logic                          irq_n
);
    ////////////////////////////////////////////////////////////////////////////
    // Input qualification, one instance per input
    logic usb_valid;
    logic adp_valid;

    isoc_input_qual u_usb_qual (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .above_min  (usb_above_min),
        .above_batt (usb_above_batt),
        .below_over (usb_below_over),
        .valid_r    (usb_valid)
    );

    isoc_input_qual u_adp_qual (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .above_min  (adapter_above_min),
        .above_batt (adapter_above_batt),
        .below_over (adapter_below_over),
        .valid_r    (adp_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Source selection and limit registers
    isoc_pkg::isoc_src_e src_r, src_nxt;
    logic [4:0] usb_lim_r, usb_lim_nxt;
    logic [4:0] adp_lim_r, adp_lim_nxt;
    logic [4:0] act_lim_r, act_lim_nxt;
    logic       throttle_r, throttle_nxt;
    logic       uv_r, uv_nxt;
    logic       boost_r;
    logic       route_usb_r, route_usb_nxt;
    logic       route_adp_r, route_adp_nxt;

    always_comb begin
        usb_lim_nxt = usb_lim_r;
        if (usb_limit_wr) begin
            usb_lim_nxt = usb_limit_wdata; // RULE_01
        end
        // Power loss wins over a host write in the same cycle
        if (!usb_power_present) begin
            usb_lim_nxt = isoc_pkg::ILIM_DEFAULT_100MA; // RULE_02
        end
        adp_lim_nxt = adp_lim_r;
        if (adapter_limit_wr) begin
            adp_lim_nxt = adapter_limit_wdata; // RULE_01
        end
        if (!usb_power_present && !adapter_power_present) begin
            adp_lim_nxt = isoc_pkg::ILIM_DEFAULT_100MA; // RULE_03
        end

        if (boost_r) begin
            src_nxt = isoc_pkg::ISOC_SRC_BOOST; // RULE_09
        end else if (usb_valid && adp_valid) begin
            src_nxt = usb_preference ? isoc_pkg::ISOC_SRC_USB
                                     : isoc_pkg::ISOC_SRC_ADAPTER; // RULE_17
        end else if (usb_valid) begin
            src_nxt = isoc_pkg::ISOC_SRC_USB; // RULE_19
        end else if (adp_valid) begin
            src_nxt = isoc_pkg::ISOC_SRC_ADAPTER; // RULE_19
        end else begin
            src_nxt = isoc_pkg::ISOC_SRC_NONE;
        end

        case (src_nxt)
            isoc_pkg::ISOC_SRC_USB:     act_lim_nxt = usb_lim_nxt; // RULE_01
            isoc_pkg::ISOC_SRC_ADAPTER: act_lim_nxt = adp_lim_nxt; // RULE_01
            default:                    act_lim_nxt = isoc_pkg::ILIM_DEFAULT_100MA;
        endcase

        // Only a throttle request; the analog loop sizes the actual cut
        throttle_nxt = input_limit_reached && (src_nxt == isoc_pkg::ISOC_SRC_USB ||
                       src_nxt == isoc_pkg::ISOC_SRC_ADAPTER); // RULE_04
        uv_nxt = input_below_uv && !undervoltage_limit_off && !boost_r; // RULE_05
        // Routes decoded ahead so both pins come straight from flops
        route_usb_nxt = (src_nxt == isoc_pkg::ISOC_SRC_USB)
                      | (src_nxt == isoc_pkg::ISOC_SRC_BOOST); // RULE_09
        route_adp_nxt = (src_nxt == isoc_pkg::ISOC_SRC_ADAPTER); // RULE_17
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            src_r      <= isoc_pkg::ISOC_SRC_NONE;
            usb_lim_r  <= isoc_pkg::ILIM_DEFAULT_100MA;
            adp_lim_r  <= isoc_pkg::ILIM_DEFAULT_100MA;
            act_lim_r  <= isoc_pkg::ILIM_DEFAULT_100MA;
            throttle_r <= 1'b0;
            uv_r       <= 1'b0;
            route_usb_r <= 1'b0;
            route_adp_r <= 1'b0;
        end else begin
            src_r      <= src_nxt;
            usb_lim_r  <= usb_lim_nxt;
            adp_lim_r  <= adp_lim_nxt;
            act_lim_r  <= act_lim_nxt;
            throttle_r <= throttle_nxt;
            uv_r       <= uv_nxt;
            route_usb_r <= route_usb_nxt;
            route_adp_r <= route_adp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Boost converter control
    typedef enum logic [1:0] {
        ISOC_B_OFF,
        ISOC_B_RUN,
        ISOC_B_FAULT
    } isoc_bst_e;

    isoc_bst_e  bst_r, bst_nxt;
    logic [31:0] short_cnt_r, short_cnt_nxt;
    logic        fault_r, fault_nxt;
    logic        battery_low_flag_r, battery_low_flag_nxt;
    logic        ident_r, ident_nxt;
    logic        inputs_powered;
    logic        start_ok;
    logic        start_req;
    logic        boost_nxt;

    always_comb begin
        inputs_powered = usb_power_present | adapter_power_present;
        start_ok  = !inputs_powered && !battery_below_low; // RULE_07
        start_req = boost_enable_request                   // RULE_14
                  || (ident_r && !auto_boost_lockout);     // RULE_06 RULE_13
        bst_nxt       = bst_r;
        short_cnt_nxt = 32'h0000_0000;
        fault_nxt     = fault_r;
        battery_low_flag_nxt    = battery_below_low; // RULE_08
        ident_nxt     = cable_ident_grounded; // RULE_11
        case (bst_r)
            ISOC_B_OFF: begin
                if (start_req && start_ok && !fault_r) begin
                    bst_nxt = ISOC_B_RUN; // RULE_06
                end
            end
            ISOC_B_RUN: begin
                if (!start_ok || boost_stop_request) begin
                    bst_nxt = ISOC_B_OFF; // RULE_07
                end else if (boost_output_short) begin
                    if (short_cnt_r >= 32'(BOOST_SHORT_CYCLES - 1)) begin
                        bst_nxt   = ISOC_B_FAULT; // RULE_10
                        fault_nxt = 1'b1;         // RULE_10
                    end else begin
                        short_cnt_nxt = short_cnt_r + 32'h0000_0001;
                    end
                end
            end
            ISOC_B_FAULT: begin
                // Stays down until host clears, avoiding restart into a short
                if (fault_clear) begin
                    bst_nxt   = ISOC_B_OFF;
                    fault_nxt = 1'b0;
                end
            end
            default: bst_nxt = ISOC_B_OFF;
        endcase
        // Running flag registered from the next state, no decode on the pin
        boost_nxt = (bst_nxt == ISOC_B_RUN);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bst_r       <= ISOC_B_OFF;
            short_cnt_r <= 32'h0000_0000;
            fault_r     <= 1'b0;
            battery_low_flag_r    <= 1'b0;
            ident_r     <= 1'b0;
            boost_r     <= 1'b0;
        end else begin
            bst_r       <= bst_nxt;
            short_cnt_r <= short_cnt_nxt;
            fault_r     <= fault_nxt;
            battery_low_flag_r    <= battery_low_flag_nxt;
            ident_r     <= ident_nxt;
            boost_r     <= boost_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event categories; set wins over clear
    logic [isoc_pkg::IRQ_W-1:0] irq_r, irq_nxt, ev;
    logic                       irq_n_r, irq_n_nxt;
    logic                       usb_valid_d, adp_valid_d, boost_d, fault_d;

    always_comb begin
        ev = '0;
        ev[isoc_pkg::IRQ_IDENT_BIT] = ident_r ^ ident_nxt; // RULE_12
        ev[isoc_pkg::IRQ_INPUT_BIT] = (usb_valid ^ usb_valid_d)
                                    | (adp_valid ^ adp_valid_d); // RULE_16
        ev[isoc_pkg::IRQ_BOOST_BIT] = (boost_r ^ boost_d) | (fault_r ^ fault_d);
        irq_nxt   = (irq_clear ? '0 : irq_r) | (ev & irq_enable); // RULE_18
        irq_n_nxt = ~(|irq_nxt);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_r       <= '0;
            irq_n_r     <= 1'b1;
            usb_valid_d <= 1'b0;
            adp_valid_d <= 1'b0;
            boost_d     <= 1'b0;
            fault_d     <= 1'b0;
        end else begin
            irq_r       <= irq_nxt;
            irq_n_r     <= irq_n_nxt;
            usb_valid_d <= usb_valid;
            adp_valid_d <= adp_valid;
            boost_d     <= boost_r;
            fault_d     <= fault_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    always_comb begin
        usb_in_current_limit_sel     = usb_lim_r;
        adapter_in_current_limit_sel = adp_lim_r;
        active_current_limit         = act_lim_r;
        charge_throttle              = throttle_r;
        uv_limit_active              = uv_r;
        usb_in_valid_flag            = usb_valid; // RULE_16
        adapter_in_valid_flag        = adp_valid; // RULE_16
        route_usb                    = route_usb_r; // RULE_09
        route_adapter                = route_adp_r;
        boost_running_flag           = boost_r; // RULE_08
        battery_low_flag             = battery_low_flag_r; // RULE_08
        boost_fault_flag             = fault_r; // RULE_08
        cable_ident_status           = ident_r; // RULE_11
        irq_status                   = irq_r;
        irq_n                        = irq_n_r;
    end
endmodule

// *** sim/isoc_top_asserts.sv ***
// Purpose: Port-level checks for input select and boost control
// Assumes: One mclk domain, rst_n synchronous active low
// Notes:   Short counter follows the shortened fault delay parameter
`timescale 1ns/1ps
module isoc_top_asserts #(
    parameter int BOOST_SHORT_CYCLES = 20
) (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       usb_power_present,
    input wire logic       adapter_power_present,
    input wire logic       battery_below_low,
    input wire logic       boost_output_short,
    input wire logic       cable_ident_grounded,
    input wire logic       usb_limit_wr,
    input wire logic [4:0] usb_limit_wdata,
    input wire logic       auto_boost_lockout,
    input wire logic       boost_enable_request,
    input wire logic       boost_stop_request,
    input wire logic [4:0] usb_in_current_limit_sel,
    input wire logic [4:0] adapter_in_current_limit_sel,
    input wire logic       boost_running_flag,
    input wire logic       boost_fault_flag,
    input wire logic       cable_ident_status
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    int short_cnt_r;
    ////////////////////////////////////////////////////////////////
    // Only shorts seen with boost running or faulted count, so idle shorts cannot trip it
    always_ff @(posedge mclk) begin
        if (!rst_n || !boost_output_short || !(boost_running_flag || boost_fault_flag)) begin
            short_cnt_r <= 0;
        end else begin
            short_cnt_r <= short_cnt_r + 1;
        end
    end
    property p_usb_def;
        !usb_power_present |=> usb_in_current_limit_sel == isoc_pkg::ILIM_DEFAULT_100MA;
    endproperty
    a_usb_def: assert property (p_usb_def) else $error("usb limit kept");
    property p_adp_def;
        !usb_power_present && !adapter_power_present
            |=> adapter_in_current_limit_sel == isoc_pkg::ILIM_DEFAULT_100MA;
    endproperty
    a_adp_def: assert property (p_adp_def) else $error("adapter limit kept");
    property p_usb_wr;
        usb_limit_wr && usb_power_present |=> usb_in_current_limit_sel == $past(usb_limit_wdata);
    endproperty
    a_usb_wr: assert property (p_usb_wr) else $error("usb limit write lost");
    property p_refuse;
        usb_power_present || adapter_power_present || battery_below_low |=> !boost_running_flag;
    endproperty
    a_refuse: assert property (p_refuse) else $error("boost ran when barred");
    property p_req;
        boost_enable_request && !usb_power_present && !adapter_power_present && !battery_below_low
            && !boost_fault_flag && !boost_stop_request && !boost_output_short
            |=> boost_running_flag;
    endproperty
    a_req: assert property (p_req) else $error("request did not start boost");
    property p_lock;
        auto_boost_lockout && !boost_enable_request && !boost_running_flag |=> !boost_running_flag;
    endproperty
    a_lock: assert property (p_lock) else $error("boost started under lockout");
    property p_ident;
        1'b1 |=> cable_ident_status == $past(cable_ident_grounded);
    endproperty
    a_ident: assert property (p_ident) else $error("ident status wrong");
    property p_short;
        short_cnt_r > BOOST_SHORT_CYCLES + 2 |-> boost_fault_flag && !boost_running_flag;
    endproperty
    a_short: assert property (p_short) else $error("short not shut down");
    c_run: cover property (boost_running_flag);
    c_fault: cover property (boost_fault_flag);
    c_ident: cover property ($rose(cable_ident_status));
endmodule
bind isoc_top isoc_top_asserts #(.BOOST_SHORT_CYCLES(BOOST_SHORT_CYCLES)) isoc_top_asserts_inst (.*);

// *** sim/isoc_host_model.sv ***
// Purpose: Host side model issuing current limit writes
// Assumes: Writes are one-cycle strobes taken on the rising edge
// Notes:   Data is scrambled after each strobe so stale values never match
`timescale 1ns/1ps
module isoc_host_model (
    input  wire logic mclk,
    output logic       usb_limit_wr,
    output logic [4:0] usb_limit_wdata,
    output logic       adapter_limit_wr,
    output logic [4:0] adapter_limit_wdata
);
    initial begin
        {usb_limit_wr, adapter_limit_wr} = 2'h0;
        {usb_limit_wdata, adapter_limit_wdata} = 10'h000;
    end
    // Leading edge keeps back-to-back calls from driving a strobe twice
    task automatic write_limit(input logic to_adp, input logic [4:0] d, input int idle);
        repeat (idle + 1) @(posedge mclk);
        if (to_adp) begin
            adapter_limit_wr <= 1'b1;
            adapter_limit_wdata <= d;
        end else begin
            usb_limit_wr <= 1'b1;
            usb_limit_wdata <= d;
        end
        @(posedge mclk);
        {usb_limit_wr, adapter_limit_wr} <= 2'h0;
        usb_limit_wdata <= ~usb_limit_wdata;
        adapter_limit_wdata <= ~adapter_limit_wdata;
    endtask
endmodule

// *** sim/test_input_select_otg_control.sv ***
// Purpose: Self-checking bench for input select and boost control
// Assumes: Notes queue feeds a negedge monitor
// Notes:   Short delay shortened to SC cycles
`timescale 1ns/1ps
module test_input_select_otg_control;
    localparam int SC = 20;
    typedef struct {string nm; logic [4:0] v;} isoc_note_s;
    logic mclk = 1'b0;
    logic rst_n, usb_above_min, usb_above_batt, usb_below_over, usb_power_present;
    logic adapter_above_min, adapter_above_batt, adapter_below_over, adapter_power_present;
    logic battery_below_low, input_below_uv, input_limit_reached, boost_output_short;
    logic cable_ident_grounded, undervoltage_limit_off, usb_preference, auto_boost_lockout;
    logic boost_enable_request, boost_stop_request, fault_clear, irq_clear, irq_n;
    logic usb_limit_wr, adapter_limit_wr, charge_throttle, uv_limit_active;
    logic usb_in_valid_flag, adapter_in_valid_flag, route_usb, route_adapter;
    logic boost_running_flag, battery_low_flag, boost_fault_flag, cable_ident_status;
    logic [isoc_pkg::IRQ_W-1:0] irq_enable, irq_status;
    logic [4:0] usb_limit_wdata, adapter_limit_wdata, usb_in_current_limit_sel, lu, la;
    logic [4:0] adapter_in_current_limit_sel, active_current_limit;
    logic [31:0] rng = 32'h0005;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    isoc_note_s note_q[$];
    isoc_top #(.BOOST_SHORT_CYCLES(SC)) isoc_top_inst (.*);
    isoc_host_model isoc_host_model_inst (.*);
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [4:0] obs(input string nm);
        case (nm)
            "usb": return usb_in_current_limit_sel;
            "adp": return adapter_in_current_limit_sel;
            "act": return active_current_limit;
            "thr": return {3'h0, uv_limit_active, charge_throttle};
            "val": return {3'h0, usb_in_valid_flag, adapter_in_valid_flag};
            "rt": return {3'h0, route_usb, route_adapter};
            "run": return {2'h0, battery_low_flag, boost_fault_flag, boost_running_flag};
            default: return {cable_ident_status, irq_n, irq_status};
        endcase
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic note(input string nm, input logic [4:0] v);
        note_q.push_back('{nm, v});
    endtask
    task automatic check(input string nm, input logic [4:0] seen, input logic [4:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic power(input logic u, input logic a);
        {usb_above_min, usb_above_batt, usb_below_over, usb_power_present} <= {4{u}};
        {adapter_above_min, adapter_above_batt, adapter_below_over, adapter_power_present} <= {4{a}};
    endtask
    task automatic complete_run;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(negedge mclk) begin
        while (note_q.size() > 0) begin
            check(note_q[0].nm, obs(note_q[0].nm), note_q[0].v);
            void'(note_q.pop_front());
        end
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        {battery_below_low, input_below_uv, input_limit_reached, boost_output_short} = 4'h0;
        {cable_ident_grounded, undervoltage_limit_off, usb_preference, auto_boost_lockout} = 4'h1;
        {boost_enable_request, boost_stop_request, fault_clear, irq_clear} = 4'h0;
        irq_enable = 3'h5;
        power(1'b0, 1'b0);
        step(10);
        rst_n <= 1'b1;
        note("usb", 5'h01);
        note("id", 5'h08);
        power(1'b1, 1'b1);
        rng = xs(rng);
        // Codes kept apart and off the default so each compare can tell them
        lu = {rng[4:2], 2'b10};
        la = {~rng[4:2], 2'b11};
        isoc_host_model_inst.write_limit(1'b0, lu, 2);
        isoc_host_model_inst.write_limit(1'b1, la, 0);
        step(2);
        note("val", 5'h03);
        note("usb", lu);
        note("adp", la);
        note("act", la);
        note("rt", 5'h01);
        note("id", 5'h04);
        usb_preference <= 1'b1;
        step(3);
        note("act", lu);
        usb_below_over <= 1'b0;
        step(3);
        note("val", 5'h01);
        note("act", la);
        for (int i = 0; i < 8; i++) begin
            {input_limit_reached, input_below_uv, undervoltage_limit_off} <= i[2:0];
            step(3);
            note("thr", {3'h0, i[1] & ~i[0], i[2]});
        end
        power(1'b0, 1'b1);
        step(3);
        note("usb", 5'h01);
        note("adp", la);
        power(1'b0, 1'b0);
        step(3);
        note("adp", 5'h01);
        irq_clear <= 1'b1;
        step(1);
        irq_clear <= 1'b0;
        cable_ident_grounded <= 1'b1;
        step(3);
        note("id", 5'h18);
        note("run", 5'h00);
        cable_ident_grounded <= 1'b0;
        irq_enable <= 3'h7;
        step(3);
        cable_ident_grounded <= 1'b1;
        step(3);
        note("id", 5'h12);
        step(1);
        irq_clear <= 1'b1;
        step(1);
        irq_clear <= 1'b0;
        {auto_boost_lockout, usb_preference} <= 2'b00;
        step(3);
        note("run", 5'h01);
        note("rt", 5'h02);
        note("id", 5'h11);
        boost_output_short <= 1'b1;
        step(SC - 4);
        note("run", 5'h01);
        step(8);
        note("run", 5'h02);
        {boost_output_short, cable_ident_grounded} <= 2'b00;
        {auto_boost_lockout, boost_enable_request} <= 2'b11;
        step(3);
        note("run", 5'h02);
        {fault_clear, battery_below_low} <= 2'b11;
        step(1);
        fault_clear <= 1'b0;
        step(3);
        note("run", 5'h04);
        battery_below_low <= 1'b0;
        step(3);
        note("run", 5'h01);
        {boost_enable_request, boost_stop_request} <= 2'b01;
        step(1);
        note("run", 5'h00);
        {boost_enable_request, boost_stop_request} <= 2'b10;
        step(3);
        note("run", 5'h01);
        power(1'b0, 1'b1);
        step(3);
        note("run", 5'h00);
        step(2);
        complete_run();
    end
endmodule
